// ### logic/mtem_timer_bank.sv
// Ten-channel 16-bit timer bank with per-channel clock gating enable, Wishbone slave
//
// Implementation choice: the Wishbone register port.
`timescale 1ns/1ps
//
// Summary of operation
// - Ten identical independent channels, linked only by listed trigger paths.
// - Modes: interval timer, event counter, pulse generation, synchronous start.
// - Capture registers hold counter values for frequency and width measurement.
// - Channel 7 output captures for 0-1, 8 for 2-4, 9 for 5-6.
// - Synchronous mode: channel 0 starts 1-3, channel 4 starts 5-7.
// - Channel has up-counter, two buffered compares, two captures, flip-flop.
// - Every channel drives its own flip-flop output pin.
// - Each channel owns a 0x40-byte window with twelve registers alike.
// - Enable bit 7 selects channel operation, resets to zero.
// - Disabled channel gets no clock to its other registers.
// - Disabled channel ignores accesses to all but the enable register.
// - Disabling a channel keeps every programmed register value.
module mtem_timer_bank
(
   input  wire logic                              clk_i,
   input  wire logic                              rst_i,
   input  wire logic                              cyc_i,
   input  wire logic                              stb_i,
   input  wire logic                              we_i,
   input  wire logic [mtem_pkg::MTEM_ADDR_W-1:0]  adr_i,
   input  wire logic [3:0]                        sel_i,
   input  wire logic [31:0]                       dat_i,
   output logic      [31:0]                       dat_o,
   output logic                                   ack_o,
   output logic                                   err_o,
   input  wire logic [mtem_pkg::MTEM_CHANNELS-1:0] channel_ext_input_0_i,
   input  wire logic [mtem_pkg::MTEM_CHANNELS-1:0] channel_ext_input_1_i,
   output logic      [mtem_pkg::MTEM_CHANNELS-1:0] channel_flipflop_out_o
);
   import mtem_pkg::*;

   localparam int N = MTEM_CHANNELS;

   // ****************************************
   // Bus decode
   // ****************************************
   function automatic logic [3:0] mtem_chan_of(input logic [MTEM_ADDR_W-1:0] a);
      mtem_chan_of = a[9:6];
   endfunction

   logic          req_w;
   logic [3:0]    chan_w;
   logic [5:0]    ofs_w;
   logic          chan_ok_w;
   logic          ofs_ok_w;
   logic          wr_lane0_w;
   logic          ack_reg;
   logic          err_reg;
   logic [31:0]   rdata_reg;
   logic [31:0]   rdata_next;

   assign req_w      = cyc_i & stb_i & ~ack_reg & ~err_reg;
   assign chan_w     = mtem_chan_of(adr_i);
   assign ofs_w      = adr_i[5:0];
   assign chan_ok_w  = (chan_w < 4'(N));
   assign ofs_ok_w   = (ofs_w[1:0] == 2'b00) && (ofs_w <= MTEM_OFS_CAP1);
   assign wr_lane0_w = req_w & we_i & sel_i[0] & chan_ok_w & ofs_ok_w;

   // ****************************************
   // Per-channel state
   // ****************************************
   logic [7:0]  en_reg   [N];
   logic [7:0]  run_reg  [N];
   logic [7:0]  ctrl_reg [N];
   logic [7:0]  mode_reg [N];
   logic [7:0]  ffc_reg  [N];
   logic [2:0]  st_reg   [N];
   logic [2:0]  msk_reg  [N];
   logic [15:0] cnt_reg  [N];
   logic [15:0] snap_reg [N];
   logic [15:0] rg0_reg  [N];
   logic [15:0] rg1_reg  [N];
   logic [15:0] rb0_reg  [N];
   logic [15:0] rb1_reg  [N];
   logic [15:0] cp0_reg  [N];
   logic [15:0] cp1_reg  [N];
   logic [N-1:0] ff_reg;
   logic [N-1:0] in0_s1_reg, in0_s2_reg, in0_s3_reg;
   logic [N-1:0] in1_s1_reg, in1_s2_reg, in1_s3_reg;
   logic [N-1:0] trg_d_reg;
   logic [N-1:0] ch_on_w;
   logic [N-1:0] run_w;

   // Routed capture trigger from channels 7..9
   function automatic int mtem_trig_src(input int ch);
      mtem_trig_src = (ch <= 1) ? 7 : (ch <= 4) ? 8 : (ch <= 6) ? 9 : -1;
   endfunction

   // Synchronous start master for each slave channel
   function automatic int mtem_sync_src(input int ch);
      mtem_sync_src = (ch >= 1 && ch <= 3) ? 0 : (ch >= 5 && ch <= 7) ? 4 : -1;
   endfunction

   // ****************************************
   // Input synchronisers
   // ****************************************
   always_ff @(posedge clk_i)
   begin
      in0_s1_reg <= channel_ext_input_0_i;
      in0_s2_reg <= in0_s1_reg;
      in0_s3_reg <= in0_s2_reg;
      in1_s1_reg <= channel_ext_input_1_i;
      in1_s2_reg <= in1_s1_reg;
      in1_s3_reg <= in1_s2_reg;
      trg_d_reg  <= ff_reg;
   end

   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : gen_ch
         localparam int TSRC = mtem_trig_src(g);
         localparam int SSRC = mtem_sync_src(g);
         logic        sel_me_w;
         logic        wr_en_w;
         logic        wr_oth_w;
         logic        cnt_edge_w;
         logic        clr_w;
         logic        hit0_w;
         logic        hit1_w;
         logic        cap0_ev_w;
         logic        cap1_ev_w;
         logic        trig_rise_w;
         logic        trig_fall_w;
         logic        swcap_w;
         logic        clk_gate_w;
         logic [15:0] cnt_next;
         logic [2:0]  st_next;
         logic        ff_next;

         assign sel_me_w   = (chan_w == 4'(g));
         assign wr_en_w    = wr_lane0_w & sel_me_w & (ofs_w == MTEM_OFS_ENABLE);
         // Gated clock modelled as a common enable: a disabled channel freezes but keeps its values
         assign clk_gate_w = en_reg[g][MTEM_EN_BIT];
         assign ch_on_w[g] = clk_gate_w;
         assign wr_oth_w   = wr_lane0_w & sel_me_w & clk_gate_w & (ofs_w != MTEM_OFS_ENABLE);

         // Run from own bit, or from the master channel in synchronous mode
         if (SSRC >= 0)
         begin : gen_sync
            assign run_w[g] = ctrl_reg[g][MTEM_SYNC_BIT] ? run_reg[SSRC][MTEM_RUN_BIT]
                                                          : run_reg[g][MTEM_RUN_BIT];
         end
         else
         begin : gen_nosync
            assign run_w[g] = run_reg[g][MTEM_RUN_BIT];
         end

         if (TSRC >= 0)
         begin : gen_trig
            assign trig_rise_w = ff_reg[TSRC] & ~trg_d_reg[TSRC];
            assign trig_fall_w = ~ff_reg[TSRC] & trg_d_reg[TSRC];
         end
         else
         begin : gen_notrig
            assign trig_rise_w = 1'b0;
            assign trig_fall_w = 1'b0;
         end

         // Event counter mode counts rising edges on input 0, otherwise every clock
         assign cnt_edge_w = mode_reg[g][MTEM_EVT_SEL_BIT] ? (in0_s2_reg[g] & ~in0_s3_reg[g]) : 1'b1;
         assign hit0_w     = run_w[g] & (cnt_reg[g] == rg0_reg[g]);
         assign hit1_w     = run_w[g] & (cnt_reg[g] == rg1_reg[g]);
         assign clr_w      = mode_reg[g][MTEM_CLR_BIT] & hit1_w;
         assign cnt_next   = !run_w[g] ? MTEM_RST_CNT :
                             clr_w ? MTEM_RST_CNT :
                             cnt_edge_w ? cnt_reg[g] + 16'h0001 : cnt_reg[g];
         // Capture from input 1 edges, or from routed flip-flop edges
         assign cap0_ev_w  = mode_reg[g][MTEM_CAPSEL_BIT] ? trig_rise_w
                                                          : (in1_s2_reg[g] & ~in1_s3_reg[g]);
         assign cap1_ev_w  = mode_reg[g][MTEM_CAPSEL_BIT] ? trig_fall_w
                                                          : (~in1_s2_reg[g] & in1_s3_reg[g]);
         assign swcap_w    = wr_oth_w & (ofs_w == MTEM_OFS_MODE) & ~dat_i[MTEM_SWCAP_BIT];
         // Pulse output toggles once in a cycle with any armed compare match, even when both match
         assign ff_next    = ff_reg[g] ^ ((hit0_w & ffc_reg[g][MTEM_FFINV0_BIT]) |
                                          (hit1_w & ffc_reg[g][MTEM_FFINV1_BIT]));
         // Status set wins over clear-on-read
         assign st_next    = ((req_w & ~we_i & sel_me_w & (ofs_w == MTEM_OFS_STATUS)) ? 3'b000 : st_reg[g])
                             | {clr_w, hit1_w, hit0_w};

         always_ff @(posedge clk_i)
         begin
            if (rst_i)
               en_reg[g] <= MTEM_RST_ENABLE;
            else if (wr_en_w)
               en_reg[g] <= dat_i[7:0] & MTEM_MSK_ENABLE;
         end

         always_ff @(posedge clk_i)
         begin
            if (rst_i)
            begin
               run_reg[g]  <= MTEM_RST_RUN;
               ctrl_reg[g] <= MTEM_RST_CTRL;
               mode_reg[g] <= MTEM_RST_MODE;
               ffc_reg[g]  <= MTEM_RST_FFCTL;
               msk_reg[g]  <= 3'b000;
               st_reg[g]   <= 3'b000;
               cnt_reg[g]  <= MTEM_RST_CNT;
               snap_reg[g] <= MTEM_RST_CNT;
               rg0_reg[g]  <= MTEM_RST_CNT;
               rg1_reg[g]  <= MTEM_RST_CNT;
               rb0_reg[g]  <= MTEM_RST_CNT;
               rb1_reg[g]  <= MTEM_RST_CNT;
               cp0_reg[g]  <= MTEM_RST_CNT;
               cp1_reg[g]  <= MTEM_RST_CNT;
               ff_reg[g]   <= 1'b0;
            end
            else if (clk_gate_w)
            begin
               cnt_reg[g] <= cnt_next;
               st_reg[g]  <= st_next;
               ff_reg[g]  <= ff_next;
               if (wr_oth_w && ofs_w == MTEM_OFS_RUN)
                  run_reg[g] <= dat_i[7:0] & MTEM_MSK_RUN;
               if (wr_oth_w && ofs_w == MTEM_OFS_CTRL)
                  ctrl_reg[g] <= dat_i[7:0] & MTEM_MSK_CTRL;
               if (wr_oth_w && ofs_w == MTEM_OFS_MODE)
                  mode_reg[g] <= dat_i[7:0] & MTEM_MSK_MODE;
               if (wr_oth_w && ofs_w == MTEM_OFS_FFCTL)
                  ffc_reg[g] <= dat_i[7:0] & MTEM_MSK_FFCTL;
               if (wr_oth_w && ofs_w == MTEM_OFS_MASK)
                  msk_reg[g] <= dat_i[2:0];
               if (req_w && !we_i && sel_me_w && ofs_w == MTEM_OFS_SNAP)
                  snap_reg[g] <= cnt_reg[g];
               // Double buffer: loads land in the buffer, move on counter clear
               if (wr_oth_w && ofs_w == MTEM_OFS_CMP0)
                  rb0_reg[g] <= dat_i[15:0];
               if (wr_oth_w && ofs_w == MTEM_OFS_CMP1)
                  rb1_reg[g] <= dat_i[15:0];
               if (wr_oth_w && ofs_w == MTEM_OFS_CMP0 && !ctrl_reg[g][MTEM_WBF_BIT])
                  rg0_reg[g] <= dat_i[15:0];
               else if (ctrl_reg[g][MTEM_WBF_BIT] && clr_w)
                  rg0_reg[g] <= rb0_reg[g];
               if (wr_oth_w && ofs_w == MTEM_OFS_CMP1 && !ctrl_reg[g][MTEM_WBF_BIT])
                  rg1_reg[g] <= dat_i[15:0];
               else if (ctrl_reg[g][MTEM_WBF_BIT] && clr_w)
                  rg1_reg[g] <= rb1_reg[g];
               if (swcap_w || cap0_ev_w)
                  cp0_reg[g] <= cnt_reg[g];
               if (cap1_ev_w)
                  cp1_reg[g] <= cnt_reg[g];
            end
         end
      end
   endgenerate

   // ****************************************
   // Read mux and answer
   // ****************************************
   always_comb
   begin
      rdata_next = 32'h0000_0000;
      if (chan_ok_w && ofs_w == MTEM_OFS_ENABLE)
         rdata_next = {24'h00_0000, en_reg[chan_w]};
      else if (chan_ok_w && ch_on_w[chan_w])
      begin
         unique case (ofs_w)
            MTEM_OFS_RUN:    rdata_next = {24'h00_0000, run_reg[chan_w]};
            MTEM_OFS_CTRL:   rdata_next = {24'h00_0000, ctrl_reg[chan_w]};
            MTEM_OFS_MODE:   rdata_next = {24'h00_0000, mode_reg[chan_w]} | MTEM_TBCP_READ;
            MTEM_OFS_FFCTL:  rdata_next = {24'h00_0000, ffc_reg[chan_w]};
            MTEM_OFS_STATUS: rdata_next = {29'h0000_0000, st_reg[chan_w]};
            MTEM_OFS_MASK:   rdata_next = {29'h0000_0000, msk_reg[chan_w]};
            MTEM_OFS_SNAP:   rdata_next = {16'h0000, cnt_reg[chan_w]};
            MTEM_OFS_CMP0:   rdata_next = {16'h0000, rg0_reg[chan_w]};
            MTEM_OFS_CMP1:   rdata_next = {16'h0000, rg1_reg[chan_w]};
            MTEM_OFS_CAP0:   rdata_next = {16'h0000, cp0_reg[chan_w]};
            MTEM_OFS_CAP1:   rdata_next = {16'h0000, cp1_reg[chan_w]};
            default:         rdata_next = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_reg   <= 1'b0;
         err_reg   <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end
      else
      begin
         ack_reg   <= req_w & chan_ok_w & ofs_ok_w;
         err_reg   <= req_w & ~(chan_ok_w & ofs_ok_w);
         rdata_reg <= rdata_next;
      end
   end

   assign dat_o                  = rdata_reg;
   assign ack_o                  = ack_reg & cyc_i & stb_i;
   assign err_o                  = err_reg & cyc_i & stb_i;
   assign channel_flipflop_out_o = ff_reg;
endmodule

// ### include/mtem_pkg.sv
// Package: register map, field positions and reset values of the timer bank
package mtem_pkg;
   localparam int          MTEM_CHANNELS     = 10;
   localparam int          MTEM_CNT_W        = 16;
   localparam int          MTEM_ADDR_W       = 10;
   // Window spacing and register offsets inside a window
   localparam logic [9:0]  MTEM_WIN_STRIDE   = 10'h040;
   localparam logic [5:0]  MTEM_OFS_ENABLE   = 6'h00;
   localparam logic [5:0]  MTEM_OFS_RUN      = 6'h04;
   localparam logic [5:0]  MTEM_OFS_CTRL     = 6'h08;
   localparam logic [5:0]  MTEM_OFS_MODE     = 6'h0C;
   localparam logic [5:0]  MTEM_OFS_FFCTL    = 6'h10;
   localparam logic [5:0]  MTEM_OFS_STATUS   = 6'h14;
   localparam logic [5:0]  MTEM_OFS_MASK     = 6'h18;
   localparam logic [5:0]  MTEM_OFS_SNAP     = 6'h1C;
   localparam logic [5:0]  MTEM_OFS_CMP0     = 6'h20;
   localparam logic [5:0]  MTEM_OFS_CMP1     = 6'h24;
   localparam logic [5:0]  MTEM_OFS_CAP0     = 6'h28;
   localparam logic [5:0]  MTEM_OFS_CAP1     = 6'h2C;
   // Field positions
   localparam int          MTEM_EN_BIT       = 7;
   localparam int          MTEM_RUN_BIT      = 0;
   localparam int          MTEM_PRUN_BIT     = 2;
   localparam int          MTEM_WBF_BIT      = 7;
   localparam int          MTEM_SYNC_BIT     = 5;
   localparam int          MTEM_SWCAP_BIT    = 5;
   localparam int          MTEM_FFINV0_BIT   = 2;
   localparam int          MTEM_FFINV1_BIT   = 3;
   localparam int          MTEM_EVT_SEL_BIT  = 0;
   localparam int          MTEM_CAPSEL_BIT   = 3;
   localparam int          MTEM_CLR_BIT      = 2;
   // Reset values
   localparam logic [7:0]  MTEM_RST_ENABLE   = 8'h00;
   localparam logic [7:0]  MTEM_RST_RUN      = 8'h00;
   localparam logic [7:0]  MTEM_RST_CTRL     = 8'h00;
   localparam logic [7:0]  MTEM_RST_MODE     = 8'h00;
   localparam logic [7:0]  MTEM_RST_FFCTL    = 8'h00;
   localparam logic [15:0] MTEM_RST_CNT      = 16'h0000;
   // Implemented bit masks per register
   localparam logic [7:0]  MTEM_MSK_ENABLE   = 8'h80;
   localparam logic [7:0]  MTEM_MSK_RUN      = 8'h05;
   localparam logic [7:0]  MTEM_MSK_CTRL     = 8'hA8;
   localparam logic [7:0]  MTEM_MSK_MODE     = 8'h1F;
   localparam logic [7:0]  MTEM_MSK_FFCTL    = 8'h0F;
   localparam logic [7:0]  MTEM_MSK_STATUS   = 8'h07;
   localparam logic [31:0] MTEM_TBCP_READ    = 32'h0000_0020;
endpackage

// ### verif/mtem_event_source.sv
// Far-side model: external event pins feeding the timer channels
`timescale 1ns/1ps
module mtem_event_source
(
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [9:0] ch_mask_i,
   input  wire logic       go_i,
   input  wire logic [7:0] count_i,
   output logic      [9:0] in0_o,
   output logic            busy_o
);
   logic [7:0] rem_reg;
   logic [1:0] ph_reg;
   assign busy_o = (rem_reg != 8'h00);
   // Two high, two low: wide enough for the two-stage synchroniser
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rem_reg <= 8'h00;
         ph_reg  <= 2'h0;
         in0_o   <= 10'h000;
      end
      else if (go_i && !busy_o)
         rem_reg <= count_i;
      else if (busy_o)
      begin
         ph_reg <= ph_reg + 2'h1;
         if (ph_reg == 2'h1)
            in0_o <= ch_mask_i;
         if (ph_reg == 2'h3)
         begin
            in0_o   <= 10'h000;
            rem_reg <= rem_reg - 8'h01;
         end
      end
   end
endmodule

// ### verif/mtem_timer_bank_asserts.sv
// Concurrent checks on the timer bank's bus and pin ports
`timescale 1ns/1ps
module mtem_timer_bank_asserts
(
   input  wire logic                               clk_i,
   input  wire logic                               rst_i,
   input  wire logic                               cyc_i,
   input  wire logic                               stb_i,
   input  wire logic                               we_i,
   input  wire logic [mtem_pkg::MTEM_ADDR_W-1:0]   adr_i,
   input  wire logic [3:0]                         sel_i,
   input  wire logic [31:0]                        dat_i,
   input  wire logic [31:0]                        dat_o,
   input  wire logic                               ack_o,
   input  wire logic                               err_o,
   input  wire logic [mtem_pkg::MTEM_CHANNELS-1:0] channel_ext_input_0_i,
   input  wire logic [mtem_pkg::MTEM_CHANNELS-1:0] channel_ext_input_1_i,
   input  wire logic [mtem_pkg::MTEM_CHANNELS-1:0] channel_flipflop_out_o
);
   import mtem_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_taken;
      cyc_i && stb_i && !ack_o && !err_o;
   endsequence
   sequence s_bad;
      s_taken ##0 (adr_i[9:6] > 4'h9 || adr_i[5:0] > 6'h2C || adr_i[1:0] != 2'h0);
   endsequence
   sequence s_good;
      s_taken ##0 (adr_i[9:6] < 4'hA && adr_i[5:0] < 6'h2D && adr_i[1:0] == 2'h0);
   endsequence
   a_req_answered: assert property (s_taken |=> (ack_o != err_o))
      else $error("request not answered next cycle");
   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_answer_caused: assert property ((ack_o || err_o) |-> $past(cyc_i && stb_i))
      else $error("answer without request");
   a_bad_adr_err: assert property (s_bad |=> err_o && !ack_o)
      else $error("unmapped address not refused");
   a_good_adr_ack: assert property (s_good |=> ack_o && !err_o)
      else $error("mapped address refused");
   a_enable_unused: assert property (s_good ##0 (!we_i && adr_i[5:0] == 6'h00) |=> (dat_o & ~32'h80) == 32'h0)
      else $error("unused enable bits read nonzero");
   a_upper_zero: assert property (ack_o && $past(!we_i) |-> dat_o[31:16] == 16'h0000)
      else $error("upper read bits nonzero");
   a_reset_clears: assert property ($fell(rst_i) |-> !ack_o && !err_o && channel_flipflop_out_o == '0)
      else $error("outputs not cleared by reset");
endmodule
bind mtem_timer_bank mtem_timer_bank_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
   .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o),
   .channel_ext_input_0_i(channel_ext_input_0_i), .channel_ext_input_1_i(channel_ext_input_1_i),
   .channel_flipflop_out_o(channel_flipflop_out_o));

// ### verif/mtem_timer_bank_tb.sv
// Self-checking bench for the ten-channel timer bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fails++; \
   $display("mismatch %s exp=%0h got=%0h", nm, e, g); end end
module mtem_timer_bank_tb;
   import mtem_pkg::*;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, err_o, go, busy;
   logic [9:0]  adr_i, in0, in1, ffo, mask;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o;
   logic [7:0]  cnt;
   int          fails = 0;
   int          n_checks = 0;
   mtem_timer_bank uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
      .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .channel_ext_input_0_i(in0),
      .channel_ext_input_1_i(in1), .channel_flipflop_out_o(ffo));
   mtem_event_source u_src (.clk_i(clk_i), .rst_i(rst_i), .ch_mask_i(mask), .go_i(go), .count_i(cnt),
      .in0_o(in0), .busy_o(busy));
   initial
   begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // ****************
   // Bus access and event pulse tasks
   // ****************
   task automatic bus(input logic [3:0] ch, input logic [5:0] ofs, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= {ch, ofs};
      dat_i <= d;
      @(posedge clk_i);
      repeat (20) if (ack_o !== 1'b1 && err_o !== 1'b1) @(posedge clk_i);
      q = dat_o;
      e = err_o;
      if (ack_o !== 1'b1 && e !== 1'b1) fails++;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [3:0] ch, input logic [5:0] ofs, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      bus(ch, ofs, 1'b1, d, q, e);
   endtask
   task automatic rd(input logic [3:0] ch, input logic [5:0] ofs, output logic [31:0] q);
      logic e;
      bus(ch, ofs, 1'b0, 32'h0, q, e);
   endtask
   task automatic pulses(input logic [9:0] m, input logic [7:0] n);
      mask <= m;
      cnt  <= n;
      go   <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i);
      repeat (200) if (busy === 1'b1) @(posedge clk_i);
      // Synchroniser latency before the count is visible
      repeat (4) @(posedge clk_i);
   endtask
   // *********
   // Scenarios
   // *********
   task automatic t_reset;
      logic [31:0] q;
      for (int c = 0; c < MTEM_CHANNELS; c++)
      begin
         rd(4'(c), MTEM_OFS_ENABLE, q);
         `CHK("enable reset", 32'h0, q)
      end
      `CHK("ff reset", 10'h000, ffo)
   endtask
   task automatic t_unmapped;
      logic [31:0] q;
      logic e;
      bus(4'hA, 6'h00, 1'b0, 32'h0, q, e);
      `CHK("err ch10", 1'b1, e)
      bus(4'h0, 6'h30, 1'b0, 32'h0, q, e);
      `CHK("err ofs", 1'b1, e)
      bus(4'h1, 6'h06, 1'b1, 32'h0, q, e);
      `CHK("err align", 1'b1, e)
   endtask
   task automatic t_gate;
      logic [31:0] q;
      wr(4'h3, MTEM_OFS_CMP0, 32'h1234);
      wr(4'h3, MTEM_OFS_ENABLE, 32'hFFFF_FFFF);
      rd(4'h3, MTEM_OFS_ENABLE, q);
      `CHK("enable bits", 32'h80, q)
      rd(4'h3, MTEM_OFS_CMP0, q);
      `CHK("ignored write", 32'h0, q)
      wr(4'h3, MTEM_OFS_CMP0, 32'hBEEF);
      wr(4'h3, MTEM_OFS_ENABLE, 32'h0);
      rd(4'h3, MTEM_OFS_CMP0, q);
      `CHK("disabled read", 32'h0, q)
      wr(4'h3, MTEM_OFS_ENABLE, 32'h80);
      rd(4'h3, MTEM_OFS_CMP0, q);
      `CHK("kept value", 32'hBEEF, q)
   endtask
   task automatic t_windows;
      logic [31:0] q;
      for (int c = 0; c < MTEM_CHANNELS; c++)
      begin
         wr(4'(c), MTEM_OFS_ENABLE, 32'h80);
         wr(4'(c), MTEM_OFS_CMP1, 32'h0A00 + 32'(c));
      end
      for (int c = 0; c < MTEM_CHANNELS; c++)
      begin
         rd(4'(c), MTEM_OFS_CMP1, q);
         `CHK("window", 32'h0A00 + 32'(c), q)
      end
   endtask
   task automatic t_events;
      logic [31:0] q;
      wr(4'h5, MTEM_OFS_MODE, 32'h1);
      wr(4'h5, MTEM_OFS_RUN, 32'h1);
      pulses(10'h020, 8'd6);
      rd(4'h5, MTEM_OFS_SNAP, q);
      `CHK("event count", 32'h6, q)
      wr(4'h5, MTEM_OFS_ENABLE, 32'h0);
      pulses(10'h020, 8'd3);
      wr(4'h5, MTEM_OFS_ENABLE, 32'h80);
      rd(4'h5, MTEM_OFS_SNAP, q);
      `CHK("frozen count", 32'h6, q)
   endtask
   task automatic t_sync;
      logic [31:0] q;
      logic [31:0] q8;
      wr(4'h1, MTEM_OFS_CTRL, 32'h20);
      wr(4'h8, MTEM_OFS_CTRL, 32'h20);
      wr(4'h0, MTEM_OFS_RUN, 32'h1);
      repeat (10) @(posedge clk_i);
      rd(4'h1, MTEM_OFS_SNAP, q);
      rd(4'h8, MTEM_OFS_SNAP, q8);
      `CHK("sync follower", 1'b1, q !== 32'h0)
      `CHK("sync outsider", 32'h0, q8)
      wr(4'h0, MTEM_OFS_RUN, 32'h0);
   endtask
   task automatic t_capture;
      logic [31:0] q0, q1;
      wr(4'h4, MTEM_OFS_RUN, 32'h1);
      repeat (5) @(posedge clk_i);
      in1 <= 10'h010;
      repeat (8) @(posedge clk_i);
      in1 <= 10'h000;
      repeat (5) @(posedge clk_i);
      rd(4'h4, MTEM_OFS_CAP0, q0);
      rd(4'h4, MTEM_OFS_CAP1, q1);
      `CHK("cap width", 32'h8, q1 - q0)
      wr(4'h4, MTEM_OFS_RUN, 32'h0);
   endtask
   task automatic t_flipflop;
      logic [31:0] q;
      // Channel 5 captures on the rise of channel 9's flip-flop
      wr(4'h5, MTEM_OFS_MODE, 32'h28);
      wr(4'h9, MTEM_OFS_CMP0, 32'h4);
      wr(4'h9, MTEM_OFS_FFCTL, 32'h4);
      wr(4'h9, MTEM_OFS_RUN, 32'h1);
      repeat (12) @(posedge clk_i);
      `CHK("ff toggle", 10'h200, ffo)
      rd(4'h5, MTEM_OFS_CAP0, q);
      `CHK("routed capture", 1'b1, q !== 32'h0)
   endtask
   task automatic report_and_stop;
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i  = 1'b0;
      adr_i = 10'h000;
      sel_i = 4'hF;
      dat_i = 32'h0;
      go    = 1'b0;
      mask  = 10'h000;
      in1   = 10'h000;
      cnt   = 8'h00;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset();
      t_unmapped();
      t_gate();
      t_windows();
      t_events();
      t_sync();
      t_capture();
      t_flipflop();
      report_and_stop();
   end
   // Whole run needs a few hundred cycles
   initial
   begin
      repeat (20000) @(posedge clk_i);
      fails++;
      report_and_stop();
   end
endmodule
